//--- common/imd_pkg.sv
// Constants for the internal data memory decoder.
// Assumes a single system clock domain and synchronous reset.
package imd_pkg;
    localparam int unsigned RAM_TOTAL = 768;
    localparam int unsigned IRAM_BYTES = 256;
    localparam int unsigned XRAM_BYTES = 512;
    localparam int unsigned SFR_BYTES = 128;
    localparam logic [7:0] UPPER_BASE = 8'h80;
    localparam logic [7:0] BANK_END = 8'h1F;
    localparam logic [7:0] BIT_BASE = 8'h20;
    localparam logic [7:0] BIT_END = 8'h2F;
    localparam logic [7:0] BIT_SPACE_END = 8'h7F;
    localparam int unsigned BANK_SHIFT = 3;
    localparam int unsigned FLASH_BYTES = 16384;
    localparam int unsigned FLASH_RSVD = 512;
    localparam int unsigned SECTOR_BYTES = 512;
    localparam logic [13:0] FLASH_USER_END = 14'h3DFF;
    localparam int unsigned SECTOR_BITS = 9;
    localparam int unsigned SECTORS = 32;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    typedef enum logic [1:0] {
        IMD_DIRECT,
        IMD_INDIRECT,
        IMD_REGREF,
        IMD_BIT
    } imd_mode_t;
    typedef enum logic [1:0] {
        IMD_FL_IDLE,
        IMD_FL_WRITE,
        IMD_FL_ERASE
    } imd_fl_st_t;
endpackage : imd_pkg

//--- hdl/imd_byte_ram.sv
// Flip-flop byte store with one read and one write port.
// Assumes the caller keeps addresses in range.
`timescale 1ns/10ps
module imd_byte_ram #(
    parameter int unsigned DEPTH = 256,
    parameter int unsigned AW = 8
) (
    input wire logic clk_sys, // System clock
    input wire logic we, // Write strobe
    input wire logic [AW-1:0] waddr, // Write index
    input wire logic [7:0] wdata, // Write byte
    input wire logic [AW-1:0] raddr, // Read index
    output logic [7:0] rdata // Read byte, combinational
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] mem_d [DEPTH];

    // Contents need no reset, like real RAM
    always_comb begin
        mem_d = mem_q;
        if (we) begin
            mem_d[waddr] = wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        mem_q <= mem_d;
    end

    assign rdata = mem_q[raddr];
endmodule : imd_byte_ram

//--- hdl/imd_decoder.sv
// Internal data memory decoder: data RAM, SFR routing, flash map.
// Assumes one core access per cycle, synchronous to clk_sys.
`timescale 1ns/10ps
// What this block does
// RQ1: 768 bytes RAM, 256 internal data
// RQ2: Upper 128 addresses decode two ways
// RQ3: Indirect upper access hits general RAM
// RQ4: Direct upper access goes to SFRs
// RQ5: Lower 128 bytes same both modes
// RQ6: Lowest 32 bytes are four banks
// RQ7: Next 16 bytes are bit addressable
// RQ8: 16 kB flash, 512 bytes reserved
// RQ9: Flash programmed in aligned 512-byte sectors
// RQ10: Illegal flash access forces unmaskable reset
// RQ11: Bank select from two status bits
// RQ12: Extra 512 bytes only external space
module imd_decoder (
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic acc_req, // Data access strobe
    input wire logic acc_wr, // 1 write, 0 read
    input wire imd_pkg::imd_mode_t acc_mode, // Addressing mode
    input wire logic [7:0] acc_addr, // Address, bit address, or Rn
    input wire logic [7:0] acc_wdata, // Write byte, bit in [0]
    input wire logic [1:0] bank_sel, // Status word bank bits
    input wire logic [7:0] sfr_rdata, // Byte from SFR space
    input wire logic x_req, // External data access strobe
    input wire logic x_wr, // External write
    input wire logic [8:0] x_addr, // External RAM address
    input wire logic [7:0] x_wdata, // External write byte
    input wire logic fl_req, // Program flash access strobe
    input wire logic fl_user, // Access from user code
    input wire logic fl_prog, // Access is an in-system write
    input wire logic fl_erase, // Sector erase request
    input wire logic [13:0] fl_addr, // Program byte address
    output logic rd_valid, // Read data valid pulse
    output logic [7:0] rd_data, // Read byte, bit in [0]
    output logic x_valid, // External read valid pulse
    output logic [7:0] x_rdata, // External read byte
    output logic sfr_sel, // SFR access pulse
    output logic sfr_wr, // SFR write pulse
    output logic [6:0] sfr_addr, // SFR index
    output logic [7:0] sfr_wdata, // SFR write byte
    output logic fl_erase_go, // Sector erase start pulse
    output logic [13:0] fl_sector_base, // Sector base being erased
    output logic flash_rst // Flash error reset pulse
);
    logic hit_sfr;
    logic [7:0] ram_idx;
    logic [7:0] bit_byte;
    logic [2:0] bit_pos;
    logic [7:0] ram_rdata;
    logic ram_we;
    logic [7:0] ram_wbyte;
    logic [7:0] xram_rdata;
    logic fl_illegal;
    logic [13:0] fl_base;

    logic rd_valid_q, rd_valid_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic x_valid_q, x_valid_d;
    logic [7:0] x_rdata_q, x_rdata_d;
    logic sfr_sel_q, sfr_sel_d;
    logic sfr_wr_q, sfr_wr_d;
    logic [6:0] sfr_addr_q, sfr_addr_d;
    logic [7:0] sfr_wdata_q, sfr_wdata_d;
    logic erase_go_q, erase_go_d;
    logic [13:0] sec_base_q, sec_base_d;
    logic flash_rst_q, flash_rst_d;
    imd_pkg::imd_fl_st_t fl_st_q, fl_st_d;

    // Bit address: 0x00..0x7F map into bytes 0x20..0x2F
    assign bit_byte = imd_pkg::BIT_BASE + {4'h0, acc_addr[6:3]}; // see RQ7
    assign bit_pos = acc_addr[2:0]; // see RQ7

    always_comb begin
        hit_sfr = 1'b0;
        ram_idx = acc_addr;
        unique case (acc_mode)
            imd_pkg::IMD_DIRECT: begin
                // Upper half is shadowed by SFRs for direct mode
                hit_sfr = acc_addr[7]; // see RQ4
                ram_idx = acc_addr; // see RQ5
            end
            imd_pkg::IMD_INDIRECT: begin
                ram_idx = acc_addr; // see RQ3
            end
            imd_pkg::IMD_REGREF: begin
                ram_idx = {3'h0, bank_sel, acc_addr[2:0]}; // see RQ6, RQ11
            end
            imd_pkg::IMD_BIT: begin
                // Bit addresses 0x80 and above belong to SFRs
                hit_sfr = acc_addr[7];
                ram_idx = bit_byte;
            end
        endcase
    end

    // Read-modify-write for single-bit stores
    always_comb begin
        ram_wbyte = acc_wdata;
        if (acc_mode == imd_pkg::IMD_BIT) begin
            ram_wbyte = ram_rdata;
            ram_wbyte[bit_pos] = acc_wdata[0]; // see RQ7
        end
    end

    assign ram_we = acc_req && acc_wr && !hit_sfr;

    // Internal data RAM, both halves, one storage per address
    imd_byte_ram #(
        .DEPTH(imd_pkg::IRAM_BYTES),
        .AW(8)
    ) u_iram (
        .clk_sys(clk_sys),
        .we(ram_we),
        .waddr(ram_idx),
        .wdata(ram_wbyte),
        .raddr(ram_idx),
        .rdata(ram_rdata)
    ); // see RQ1, RQ2

    // Extra RAM only on the external data port
    imd_byte_ram #(
        .DEPTH(imd_pkg::XRAM_BYTES),
        .AW(9)
    ) u_xram (
        .clk_sys(clk_sys),
        .we(x_req && x_wr),
        .waddr(x_addr),
        .wdata(x_wdata),
        .raddr(x_addr),
        .rdata(xram_rdata)
    ); // see RQ1, RQ12

    imd_flash_guard u_guard (
        .addr(fl_addr),
        .user_acc(fl_req && fl_user),
        .illegal(fl_illegal),
        .sector(),
        .sector_base(fl_base)
    );

    always_comb begin
        rd_valid_d = acc_req && !acc_wr && !hit_sfr;
        rd_data_d = rd_data_q;
        if (rd_valid_d) begin
            if (acc_mode == imd_pkg::IMD_BIT) begin
                rd_data_d = {7'h00, ram_rdata[bit_pos]};
            end else begin
                rd_data_d = ram_rdata;
            end
        end
        sfr_sel_d = acc_req && hit_sfr; // see RQ4
        sfr_wr_d = acc_req && hit_sfr && acc_wr;
        sfr_addr_d = acc_addr[6:0];
        sfr_wdata_d = acc_wdata;
        x_valid_d = x_req && !x_wr; // see RQ12
        x_rdata_d = x_valid_d ? xram_rdata : x_rdata_q;
    end

    // Flash side: erase sequencing and error reset
    always_comb begin
        fl_st_d = fl_st_q;
        erase_go_d = 1'b0;
        sec_base_d = sec_base_q;
        // Reset source has no enable at all
        flash_rst_d = fl_illegal && (fl_prog || fl_erase || fl_req); // see RQ10
        unique case (fl_st_q)
            imd_pkg::IMD_FL_IDLE: begin
                if (fl_req && fl_erase && !fl_illegal) begin
                    fl_st_d = imd_pkg::IMD_FL_ERASE;
                    erase_go_d = 1'b1;
                    sec_base_d = fl_base; // see RQ9
                end else if (fl_req && fl_prog && !fl_illegal) begin
                    fl_st_d = imd_pkg::IMD_FL_WRITE;
                end
            end
            imd_pkg::IMD_FL_WRITE: begin
                fl_st_d = imd_pkg::IMD_FL_IDLE;
            end
            imd_pkg::IMD_FL_ERASE: begin
                fl_st_d = imd_pkg::IMD_FL_IDLE;
            end
            default: begin
                fl_st_d = imd_pkg::IMD_FL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= imd_pkg::ZERO_BYTE;
            x_valid_q <= 1'b0;
            x_rdata_q <= imd_pkg::ZERO_BYTE;
            sfr_sel_q <= 1'b0;
            sfr_wr_q <= 1'b0;
            sfr_addr_q <= 7'h00;
            sfr_wdata_q <= imd_pkg::ZERO_BYTE;
            erase_go_q <= 1'b0;
            sec_base_q <= 14'h0000;
            flash_rst_q <= 1'b0;
            fl_st_q <= imd_pkg::IMD_FL_IDLE;
        end else begin
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            x_valid_q <= x_valid_d;
            x_rdata_q <= x_rdata_d;
            sfr_sel_q <= sfr_sel_d;
            sfr_wr_q <= sfr_wr_d;
            sfr_addr_q <= sfr_addr_d;
            sfr_wdata_q <= sfr_wdata_d;
            erase_go_q <= erase_go_d;
            sec_base_q <= sec_base_d;
            flash_rst_q <= flash_rst_d;
            fl_st_q <= fl_st_d;
        end
    end

    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign x_valid = x_valid_q;
    assign x_rdata = x_rdata_q;
    assign sfr_sel = sfr_sel_q;
    assign sfr_wr = sfr_wr_q;
    assign sfr_addr = sfr_addr_q;
    assign sfr_wdata = sfr_wdata_q;
    assign fl_erase_go = erase_go_q;
    assign fl_sector_base = sec_base_q;
    assign flash_rst = flash_rst_q;

    sequence s_upper_direct;
        acc_req && acc_mode == imd_pkg::IMD_DIRECT && acc_addr[7];
    endsequence

    a_direct_to_sfr: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RQ4
        s_upper_direct |=> sfr_sel && !rd_valid && sfr_addr == $past(acc_addr[6:0]))
        else $error("direct upper access not routed to SFR");

    a_indirect_ram: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RQ3
        acc_req && acc_mode == imd_pkg::IMD_INDIRECT |=> !sfr_sel)
        else $error("indirect access reached SFR");

    a_indirect_read: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RQ3
        acc_req && !acc_wr && acc_mode == imd_pkg::IMD_INDIRECT |=> rd_valid)
        else $error("indirect read gave no data");

    sequence s_lower_direct_wr;
        acc_req && acc_wr && acc_mode == imd_pkg::IMD_DIRECT && !acc_addr[7];
    endsequence

    sequence s_same_indirect_rd;
        acc_req && !acc_wr && acc_mode == imd_pkg::IMD_INDIRECT
        && acc_addr == $past(acc_addr);
    endsequence

    a_lower_shared: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RQ5
        s_lower_direct_wr ##1 s_same_indirect_rd
        |=> rd_data == $past(acc_wdata, 2))
        else $error("lower RAM differs between modes");

    // Bank base is the select field times eight
    a_bank_regref: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RQ6
        acc_req && acc_mode == imd_pkg::IMD_REGREF |-> ram_idx <= imd_pkg::BANK_END
        && ram_idx == ({6'h00, bank_sel} << imd_pkg::BANK_SHIFT)
        + {5'h00, acc_addr[2:0]})
        else $error("register reference left its bank");

    a_bit_read: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RQ7
        acc_req && !acc_wr && acc_mode == imd_pkg::IMD_BIT && !acc_addr[7]
        |=> rd_valid && rd_data[7:1] == 7'h00)
        else $error("bit read not a single bit");

    a_bit_area: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RQ7
        acc_req && acc_mode == imd_pkg::IMD_BIT && !acc_addr[7]
        |-> bit_byte >= imd_pkg::BIT_BASE && bit_byte <= imd_pkg::BIT_END)
        else $error("bit address outside bit area");

    a_flash_reset: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RQ10
        fl_req && fl_user && fl_addr > imd_pkg::FLASH_USER_END |=> flash_rst)
        else $error("illegal flash access gave no reset");

    a_sector_align: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RQ9
        fl_erase_go |-> fl_sector_base[8:0] == 9'h000 && fl_st_q == imd_pkg::IMD_FL_ERASE)
        else $error("erase sector not aligned");
endmodule : imd_decoder

//--- hdl/imd_flash_guard.sv
// Program flash map checker: reserved tail and sector alignment.
// Assumes the core flags each program-side access with a strobe.
`timescale 1ns/10ps
module imd_flash_guard (
    input wire logic [13:0] addr, // Program byte address
    input wire logic user_acc, // Access from user code
    output logic illegal, // Access hits reserved area
    output logic [4:0] sector, // Sector of the address
    output logic [13:0] sector_base // Aligned sector start
);
    // Reserved tail is not user program space
    assign illegal = user_acc && (addr > imd_pkg::FLASH_USER_END); // see RQ8
    assign sector = addr[13:imd_pkg::SECTOR_BITS]; // see RQ9
    assign sector_base = {addr[13:imd_pkg::SECTOR_BITS], 9'h000}; // see RQ9
endmodule : imd_flash_guard

//--- verif/imd_core_model.sv
// Core model: issues data, external and flash requests.
// Assumes the bench calls one task per cycle and idle between phases.
`timescale 1ns/10ps
module imd_core_model (
    input wire logic clk_sys, // System clock
    output logic acc_req, // Data strobe
    output logic acc_wr, // Data write
    output imd_pkg::imd_mode_t acc_mode, // Addressing mode
    output logic [7:0] acc_addr, // Data address
    output logic [7:0] acc_wdata, // Data byte
    output logic [1:0] bank_sel, // Bank bits
    output logic x_req, // External strobe
    output logic x_wr, // External write
    output logic [8:0] x_addr, // External address
    output logic [7:0] x_wdata, // External byte
    output logic fl_req, // Flash strobe
    output logic fl_user, // User code access
    output logic fl_prog, // Flash write
    output logic fl_erase, // Sector erase
    output logic [13:0] fl_addr // Flash address
);
    initial begin
        {acc_req, acc_wr, acc_addr, acc_wdata, bank_sel} = '0;
        acc_mode = imd_pkg::IMD_DIRECT;
        {x_req, x_wr, x_addr, x_wdata} = '0;
        {fl_req, fl_user, fl_prog, fl_erase, fl_addr} = '0;
    end
    // Strobes drop together; qualifiers keep their last values
    task automatic idle();
        @(negedge clk_sys);
        acc_req = 1'b0;
        x_req = 1'b0;
        fl_req = 1'b0;
    endtask : idle
    task automatic data_acc(input logic w, input imd_pkg::imd_mode_t m,
            input logic [7:0] a, input logic [7:0] d, input logic [1:0] b);
        @(negedge clk_sys);
        acc_req = 1'b1;
        acc_wr = w;
        acc_mode = m;
        acc_addr = a;
        acc_wdata = d;
        bank_sel = b;
    endtask : data_acc
    task automatic ext_acc(input logic w, input logic [8:0] a,
            input logic [7:0] d);
        @(negedge clk_sys);
        x_req = 1'b1;
        x_wr = w;
        x_addr = a;
        x_wdata = d;
    endtask : ext_acc
    task automatic fl_acc(input logic u, input logic p, input logic e,
            input logic [13:0] a);
        @(negedge clk_sys);
        fl_req = 1'b1;
        fl_user = u;
        fl_prog = p;
        fl_erase = e;
        fl_addr = a;
    endtask : fl_acc
endmodule : imd_core_model

//--- verif/imd_decoder_tb.sv
// Bench for the decoder: reference stores and a queue of expected answers.
// Assumes the core model drives every request port.
`timescale 1ns/10ps
module imd_decoder_tb;
    localparam imd_pkg::imd_mode_t DIR = imd_pkg::IMD_DIRECT;
    localparam imd_pkg::imd_mode_t IND = imd_pkg::IMD_INDIRECT;
    localparam imd_pkg::imd_mode_t RGR = imd_pkg::IMD_REGREF;
    localparam imd_pkg::imd_mode_t BTM = imd_pkg::IMD_BIT;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_rdata = 8'h5A;
    logic acc_req, acc_wr, x_req, x_wr, fl_req, fl_user, fl_prog, fl_erase;
    imd_pkg::imd_mode_t acc_mode;
    logic [7:0] acc_addr, acc_wdata, x_wdata, rd_data, x_rdata, sfr_wdata;
    logic [1:0] bank_sel;
    logic [8:0] x_addr;
    logic [13:0] fl_addr, fl_sector_base;
    logic rd_valid, x_valid, sfr_sel, sfr_wr, fl_erase_go, flash_rst;
    logic [6:0] sfr_addr;
    logic [15:0] sfr_seen;
    logic [7:0] ram [256];
    logic [7:0] xram [512];
    logic [18:0] notes [$];
    int bad_count = 0;
    int checks = 0;
    assign sfr_seen = {sfr_wr, sfr_addr, sfr_wr ? sfr_wdata : 8'h00};
    always #25 clk_sys = ~clk_sys;
    imd_core_model imd_core_model_i (.clk_sys, .acc_req, .acc_wr, .acc_mode,
        .acc_addr, .acc_wdata, .bank_sel, .x_req, .x_wr, .x_addr, .x_wdata,
        .fl_req, .fl_user, .fl_prog, .fl_erase, .fl_addr);
    imd_decoder imd_decoder_i (.clk_sys, .sys_rst, .acc_req, .acc_wr,
        .acc_mode, .acc_addr, .acc_wdata, .bank_sel, .sfr_rdata, .x_req,
        .x_wr, .x_addr, .x_wdata, .fl_req, .fl_user, .fl_prog, .fl_erase,
        .fl_addr, .rd_valid, .rd_data, .x_valid, .x_rdata, .sfr_sel, .sfr_wr,
        .sfr_addr, .sfr_wdata, .fl_erase_go, .fl_sector_base, .flash_rst);
    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    // An answer with no note pending meets an impossible note
    task automatic take(input logic [2:0] k, input logic [15:0] v);
        logic [18:0] e;
        e = (notes.size() > 0) ? notes.pop_front() : 19'h7FFFF;
        // Upper bits of a bit read must be zero, so v is kept whole
        if (k == 3'd1 && e[18:16] == 3'd5) begin
            k = 3'd5;
        end
        check({k, v}, e);
    endtask : take
    always @(negedge clk_sys) begin
        if (rd_valid === 1'b1) take(3'd1, {8'h00, rd_data});
        if (sfr_sel === 1'b1) take(3'd2, sfr_seen);
        if (x_valid === 1'b1) take(3'd3, {8'h00, x_rdata});
        if (fl_erase_go === 1'b1) take(3'd4, {2'b00, fl_sector_base});
        if (flash_rst === 1'b1) take(3'd6, 16'h0000);
    end
    task automatic dacc(input logic w, input imd_pkg::imd_mode_t m,
            input logic [7:0] a, input logic [7:0] d, input logic [1:0] b);
        logic [7:0] i;
        i = (m == RGR) ? {3'b000, b, a[2:0]} : a;
        if (m == BTM) i = 8'h20 + {4'h0, a[6:3]};
        if (a[7] && (m == DIR || m == BTM))
            notes.push_back({3'd2, w, a[6:0], w ? d : 8'h00});
        else if (w && m == BTM) ram[i][a[2:0]] = d[0];
        else if (w) ram[i] = d;
        else if (m == BTM) notes.push_back({3'd5, 15'h0000, ram[i][a[2:0]]});
        else notes.push_back({3'd1, 8'h00, ram[i]});
        imd_core_model_i.data_acc(w, m, a, d, b);
    endtask : dacc
    task automatic xacc(input logic w, input logic [8:0] a,
            input logic [7:0] d);
        if (w) xram[a] = d;
        else notes.push_back({3'd3, 8'h00, xram[a]});
        imd_core_model_i.ext_acc(w, a, d);
    endtask : xacc
    // Two cycles per request keeps clear of the busy cycle
    task automatic facc(input logic u, input logic p, input logic e,
            input logic [13:0] a);
        if (u && a > 14'h3DFF) notes.push_back({3'd6, 16'h0000});
        else if (e) notes.push_back({3'd4, 2'b00, a[13:9], 9'h000});
        imd_core_model_i.fl_acc(u, p, e, a);
        imd_core_model_i.idle();
    endtask : facc
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        logic [8:0] xa;
        void'($urandom(32'hACB3C6E7));
        repeat (6) @(negedge clk_sys);
        sys_rst = 1'b0;
        for (int i = 0; i < 256; i++) dacc(1'b1, IND, i[7:0], 8'($urandom),
            2'b00);
        // Random read or write then read at once, direct and indirect mixed at random
        for (int i = 0; i < 300; i++) begin
            a = 8'($urandom);
            d = 8'($urandom);
            dacc(1'($urandom), imd_pkg::imd_mode_t'(2'($urandom % 2)), a, d,
                2'b00);
            dacc(1'b0, imd_pkg::imd_mode_t'(2'($urandom % 2)), a, d, 2'b00);
        end
        for (int i = 0; i < 32; i++) begin
            a = {5'($urandom), i[2:0]};
            dacc(1'b1, RGR, a, 8'($urandom), i[4:3]);
            dacc(1'b0, IND, {3'b000, i[4:0]}, d, 2'($urandom));
            dacc(1'b0, RGR, a, d, i[4:3]);
        end
        for (int i = 0; i < 60; i++) begin
            a = 8'($urandom);
            dacc(1'b1, BTM, {1'b0, a[6:0]}, 8'($urandom), 2'b00);
            dacc(1'b0, BTM, a, d, 2'b00);
            dacc(1'b0, IND, 8'h20 + {4'h0, a[6:3]}, d, 2'b00);
        end
        imd_core_model_i.idle();
        for (int i = 0; i < 512; i++) xacc(1'b1, i[8:0], 8'($urandom));
        for (int i = 0; i < 200; i++) begin
            xa = 9'($urandom);
            xacc(1'($urandom), xa, 8'($urandom));
            xacc(1'b0, xa, d);
        end
        imd_core_model_i.idle();
        for (int i = 0; i < 256; i++) dacc(1'b0, IND, i[7:0], d,
            2'b00);
        imd_core_model_i.idle();
        facc(1'b1, 1'b0, 1'b1, 14'h3DFF);
        facc(1'b1, 1'b0, 1'b0, 14'h3E00);
        facc(1'b1, 1'b1, 1'b0, 14'h3FFF);
        facc(1'b0, 1'b0, 1'b1, 14'h3E00);
        // Second erase in the busy cycle must be ignored
        notes.push_back({3'd4, 2'b00, 5'h03, 9'h000});
        imd_core_model_i.fl_acc(1'b1, 1'b0, 1'b1, 14'h0745);
        imd_core_model_i.fl_acc(1'b1, 1'b0, 1'b1, 14'h1200);
        imd_core_model_i.idle();
        for (int i = 0; i < 40; i++) begin
            d = 8'($urandom);
            facc(d[0], d[1] & ~d[2], d[2], 14'($urandom));
        end
        for (int i = 0; i < 20 && notes.size() > 0; i++) @(negedge clk_sys);
        if (notes.size() > 0) bad_count++;
        print_verdict();
    end
endmodule : imd_decoder_tb
